// File: hdl/eic_controller.sv
// Terminal module controller end of the external index link
module eic_controller
	import eic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	eic_link_if.controller link,
	input wire logic char_ready,
	input wire logic [DATA_W-1:0] char_data,
	input wire logic [IDENT_W-1:0] identifier,
	input wire logic want_output,
	output logic [WORD_W-1:0] out_seen,
	output logic out_seen_valid,
	output logic function_seen
);
	typedef enum {EIC_IDLE, EIC_IN_REQ, EIC_OUT_REQ} eic_state_t;
	eic_state_t state_reg;
	logic fa_reg;
	logic [WORD_W-1:0] in_word_reg;

	assign link.function_accept = fa_reg;
	assign link.in_word = in_word_reg;
	assign link.input_data_request = (state_reg == EIC_IN_REQ);
	assign link.output_data_request = (state_reg == EIC_OUT_REQ);

	// Service request held until acknowledge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= EIC_IDLE;
			in_word_reg <= WORD_RESET;
		end else begin
			unique case (state_reg)
				EIC_IDLE: begin
					if (char_ready) begin
						in_word_reg <= {char_data, identifier};
						state_reg <= EIC_IN_REQ;
					end else if (want_output) begin
						in_word_reg <= {18'h0_0000, identifier};
						state_reg <= EIC_OUT_REQ;
					end
				end
				EIC_IN_REQ: if (link.input_ack) state_reg <= EIC_IDLE;
				EIC_OUT_REQ: if (link.output_ack) state_reg <= EIC_IDLE;
			endcase
		end
	end

	// Accept function words and capture output data
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fa_reg <= 1'b0;
			function_seen <= 1'b0;
			out_seen <= WORD_RESET;
			out_seen_valid <= 1'b0;
		end else begin
			fa_reg <= link.function_strobe && !fa_reg;
			function_seen <= link.function_strobe && !fa_reg;
			out_seen_valid <= link.out_word_valid;
			if (link.out_word_valid) begin
				out_seen <= link.out_word;
			end
		end
	end
endmodule : eic_controller

// File: hdl/eic_link_if.sv
// Link between processor channel and terminal controller
interface eic_link_if;
	import eic_pkg::*;
	logic [WORD_W-1:0] out_word;
	logic out_word_valid;
	logic function_strobe;
	logic function_accept;
	logic output_data_request;
	logic output_ack;
	logic input_data_request;
	logic [WORD_W-1:0] in_word;
	logic input_ack;
	modport processor (output out_word, output out_word_valid, output function_strobe,
		input function_accept, input output_data_request, output output_ack,
		input input_data_request, input in_word, output input_ack);
	modport controller (input out_word, input out_word_valid, input function_strobe,
		output function_accept, output output_data_request, input output_ack,
		output input_data_request, output in_word, input input_ack);
endinterface : eic_link_if

// File: hdl/eic_pkg.sv
// Shared constants and types for the external index channel link
package eic_pkg;
	localparam int WORD_W = 36;
	localparam int IDENT_W = 18;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 15;
	// Identifier field layout
	localparam int PRIO_LSB = 0;
	localparam int PRIO_W = 6;
	localparam int BIAS_LSB = 6;
	localparam int BIAS_W = 9;
	localparam int MSR_LSB = 15;
	localparam int MSR_W = 2;
	// Access-control word layout
	localparam int ACW_ADDR_LSB = 0;
	localparam int ACW_CNT_LSB = 18;
	localparam int ACW_CNT_W = 18;
	localparam int ACW_ENTRIES = 64;
	// Control location figures (hex); channel count in decimal
	localparam logic [7:0] IN_ACW_BASE = 8'h20;
	localparam logic [7:0] OUT_ACW_BASE = 8'h30;
	localparam logic [7:0] CTRL_REG_LIMIT = 8'h80;
	localparam int NUM_CHAN = 16;
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int FUNC_GAP_NS = 3750;
	localparam int FUNC_GAP_CYC = (FUNC_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BUSY_TIMEOUT_NS = 2000;
	localparam int BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;
	localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;
	typedef enum logic [1:0] {EIC_IDLE_T0, EIC_D1, EIC_D2, EIC_D3} eic_dummy_t;
endpackage : eic_pkg

// File: hdl/eic_processor.sv
// Processor-side external index channel engine
// Operation
// - Output monitored activation arms output requests
// - Activation writes to output location suppressed
// - Software uses activation operand below octal 200
// - Function word requests data request plus identifier
// - Store identifier in input control location
// - Identifier selects governing access-control word
// - Output busy test has timeout
// - Module requests service; controller sends identifier
// - Acknowledge each input word taken
// - Module drops request on acknowledge
// - Input monitored activation arms input requests
// - Full buffer raises monitor interrupt
// - Line terminal input ended by function
// - Wait for function departure before output
// - Drum: terminate, wait output busy first
// - Decode identifier: module, base, priority
// - Function gap at least 3.75 us
// - Update address and count each word
module eic_processor
	import eic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	eic_link_if.processor link,
	input wire logic [3:0] chan_sel,
	input wire logic load_output_monitored,
	input wire logic load_input_monitored,
	input wire logic [7:0] operand_addr,
	input wire logic load_function_channel_instr,
	input wire logic [WORD_W-1:0] function_word,
	input wire logic jump_output_busy,
	input wire logic acw_write,
	input wire logic [5:0] acw_index,
	input wire logic [WORD_W-1:0] acw_data,
	input wire logic [DATA_W-1:0] out_fill_data,
	input wire logic out_fill_valid,
	output logic out_fill_ready,
	output logic [DATA_W-1:0] in_data,
	output logic in_data_valid,
	input wire logic in_data_ready,
	output logic jump_function_pending,
	output logic busy_timeout,
	output logic monitor_interrupt,
	output logic [IDENT_W-1:0] last_identifier,
	output logic [MSR_W-1:0] storage_module_select,
	output logic [BIAS_W-1:0] block_base,
	output logic [7:0] suppressed_target,
	output logic fast_suppressed
);
	logic out_armed_reg;
	logic in_armed_reg;
	logic [WORD_W-1:0] acw_reg [ACW_ENTRIES];
	logic [WORD_W-1:0] ctl_out_reg;
	logic [WORD_W-1:0] out_word_reg;
	logic out_word_valid_reg;
	logic function_strobe_reg;
	logic output_ack_reg;
	logic input_ack_reg;
	logic [15:0] gap_cnt_reg;
	logic [15:0] busy_cnt_reg;
	logic busy_wait_reg;
	logic [DATA_W-1:0] buf_data_reg [2];
	logic [1:0] buf_cnt_reg;
	logic buf_wp_reg;
	logic buf_rp_reg;
	logic [1:0] buf_cnt_next;
	logic [5:0] prio;
	logic gap_clear;
	logic buf_push;
	logic buf_pop;
	logic out_take;
	logic in_take;

	assign prio = link.in_word[PRIO_LSB +: PRIO_W];
	assign gap_clear = (gap_cnt_reg == 16'h0000);
	// No take while a function load or table write owns this edge, else a word is acked but lost (function load) or left uncounted (table write)
	assign out_take = out_armed_reg && link.output_data_request && !output_ack_reg
		&& !out_word_valid_reg && !jump_function_pending && gap_clear
		&& !load_function_channel_instr && !acw_write
		&& buf_cnt_reg != 2'h0;
	assign in_take = in_armed_reg && link.input_data_request && !input_ack_reg
		&& !in_data_valid && !acw_write;
	assign buf_push = out_fill_valid && out_fill_ready;
	assign buf_pop = out_take;
	assign buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
	assign link.out_word = out_word_reg;
	assign link.out_word_valid = out_word_valid_reg;
	assign link.function_strobe = function_strobe_reg;
	assign link.output_ack = output_ack_reg;
	assign link.input_ack = input_ack_reg;

	// Arming; control location write is inhibited in external index mode
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			out_armed_reg <= 1'b0;
			in_armed_reg <= 1'b0;
			suppressed_target <= 8'h00;
			fast_suppressed <= 1'b0;
		end else begin
			if (load_output_monitored) begin
				out_armed_reg <= 1'b1;
				suppressed_target <= OUT_ACW_BASE + {4'h0, chan_sel};
				fast_suppressed <= operand_addr < CTRL_REG_LIMIT;
			end
			if (load_input_monitored) begin
				in_armed_reg <= 1'b1;
				suppressed_target <= IN_ACW_BASE + {4'h0, chan_sel};
				fast_suppressed <= operand_addr < CTRL_REG_LIMIT;
			end
			// Line terminal sync function ends input
			if (load_function_channel_instr) begin
				in_armed_reg <= 1'b0;
			end
		end
	end

	// Output control location keeps its contents: written here only by reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_out_reg <= WORD_RESET;
		end else begin
			ctl_out_reg <= ctl_out_reg;
		end
	end

	// Function word send and pending flag, then post-function gap
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			out_word_reg <= WORD_RESET;
			out_word_valid_reg <= 1'b0;
			function_strobe_reg <= 1'b0;
			jump_function_pending <= 1'b0;
			gap_cnt_reg <= 16'h0000;
		end else begin
			out_word_valid_reg <= 1'b0; // One-cycle pulse, even if a function load follows
			if (gap_cnt_reg != 16'h0000) begin
				gap_cnt_reg <= gap_cnt_reg - 16'h0001;
			end
			if (load_function_channel_instr && !jump_function_pending) begin
				out_word_reg <= function_word;
				function_strobe_reg <= 1'b1;
				jump_function_pending <= 1'b1;
			end else if (jump_function_pending && link.function_accept) begin
				function_strobe_reg <= 1'b0;
				jump_function_pending <= 1'b0;
				gap_cnt_reg <= 16'(FUNC_GAP_CYC);
			end else if (out_take) begin
				out_word_reg <= {18'h0_0000, buf_data_reg[buf_rp_reg]};
				out_word_valid_reg <= 1'b1;
			end
		end
	end

	// Acknowledges, one per request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			output_ack_reg <= 1'b0;
			input_ack_reg <= 1'b0;
		end else begin
			output_ack_reg <= out_take ? 1'b1 : (link.output_data_request & output_ack_reg);
			input_ack_reg <= in_take ? 1'b1 : (link.input_data_request & input_ack_reg);
		end
	end

	// Identifier capture, decode, access-control update
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			last_identifier <= 18'h0_0000;
			storage_module_select <= 2'h0;
			block_base <= 9'h000;
			monitor_interrupt <= 1'b0;
			in_data <= 18'h0_0000;
			in_data_valid <= 1'b0;
			for (int i = 0; i < ACW_ENTRIES; i++) begin
				acw_reg[i] <= WORD_RESET;
			end
		end else begin
			monitor_interrupt <= 1'b0;
			if (in_data_valid && in_data_ready) begin
				in_data_valid <= 1'b0;
			end
			if (acw_write) begin
				acw_reg[acw_index] <= acw_data;
			end else if (in_take || out_take) begin
				last_identifier <= link.in_word[IDENT_W-1:0];
				storage_module_select <= link.in_word[MSR_LSB +: MSR_W];
				block_base <= link.in_word[BIAS_LSB +: BIAS_W];
				acw_reg[prio] <= {acw_reg[prio][ACW_CNT_LSB +: ACW_CNT_W] - 18'h0_0001,
					acw_reg[prio][ACW_ADDR_LSB +: ACW_CNT_W] + 18'h0_0001};
				if (acw_reg[prio][ACW_CNT_LSB +: ACW_CNT_W] == 18'h0_0001) begin
					monitor_interrupt <= 1'b1;
				end
				if (in_take) begin
					in_data <= link.in_word[WORD_W-1 -: DATA_W];
					in_data_valid <= 1'b1;
				end
			end
		end
	end

	// Busy test with timeout waiting on output data request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_wait_reg <= 1'b0;
			busy_cnt_reg <= 16'h0000;
			busy_timeout <= 1'b0;
		end else begin
			busy_timeout <= 1'b0;
			if (jump_output_busy && !busy_wait_reg) begin
				busy_wait_reg <= 1'b1;
				busy_cnt_reg <= 16'(BUSY_TIMEOUT_CYC);
			end else if (busy_wait_reg) begin
				if (link.output_data_request) begin
					busy_wait_reg <= 1'b0;
				end else if (busy_cnt_reg == 16'h0001) begin
					busy_wait_reg <= 1'b0;
					busy_timeout <= 1'b1;
				end else begin
					busy_cnt_reg <= busy_cnt_reg - 16'h0001;
				end
			end
		end
	end

	// Two-entry output buffer so a stalled source loses no word
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			buf_cnt_reg <= 2'h0;
			out_fill_ready <= 1'b0;
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_data_reg[0] <= 18'h0_0000;
			buf_data_reg[1] <= 18'h0_0000;
		end else begin
			if (buf_push) begin
				buf_data_reg[buf_wp_reg] <= out_fill_data;
				buf_wp_reg <= ~buf_wp_reg;
			end
			if (buf_pop) begin
				buf_rp_reg <= ~buf_rp_reg;
			end
			buf_cnt_reg <= buf_cnt_next;
			out_fill_ready <= (buf_cnt_next != 2'h2); // Registered so ready comes from a flop
		end
	end
endmodule : eic_processor

// File: verification/eic_props.sv
// Link checker for the processor and controller ends
module eic_props
	import eic_pkg::*;
#(
	parameter int GAP = FUNC_GAP_CYC
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WORD_W-1:0] out_word,
	input wire logic out_word_valid,
	input wire logic function_strobe,
	input wire logic function_accept,
	input wire logic output_data_request,
	input wire logic output_ack,
	input wire logic input_data_request,
	input wire logic [WORD_W-1:0] in_word,
	input wire logic input_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Cycles since last accepted function, saturating so no wrap hides a breach
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) gap_cnt <= GAP;
		else if (function_accept) gap_cnt <= 0;
		else if (gap_cnt < GAP) gap_cnt <= gap_cnt + 1;
	end
	a_in_ack_cause: assert property ($rose(input_ack) |-> $past(input_data_request))
		else $error("input ack without request");
	a_in_req_drop: assert property (input_ack && input_data_request |=> !input_data_request)
		else $error("input request held after ack");
	a_in_ack_release: assert property (input_ack && !input_data_request |=> !input_ack)
		else $error("input ack not released");
	a_in_req_hold: assert property (input_data_request && !input_ack
		|=> input_data_request && $stable(in_word)) else $error("input request not held");
	a_out_ack_cause: assert property ($rose(output_ack)
		|-> $past(output_data_request) && out_word_valid) else $error("output ack without request");
	a_out_ack_release: assert property (output_ack && !output_data_request |=> !output_ack)
		else $error("output ack not released");
	a_func_hold: assert property (function_strobe && !function_accept |=> function_strobe)
		else $error("function strobe dropped early");
	a_func_clear: assert property (function_accept |=> !function_strobe)
		else $error("function strobe stuck after accept");
	a_gap_kept: assert property (out_word_valid |-> gap_cnt >= GAP - 1 && !function_strobe)
		else $error("output word inside function gap");
endmodule : eic_props

// File: verification/tb.sv
// Testbench joining processor and controller ends over the link
module tb
	import eic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] chan_sel = 4'h1;
	logic load_output_monitored = 1'b0, load_input_monitored = 1'b0;
	logic load_function_channel_instr = 1'b0, jump_output_busy = 1'b0, acw_write = 1'b0;
	logic out_fill_valid = 1'b0, in_data_ready = 1'b1, char_ready = 1'b0, want_output = 1'b0;
	logic [7:0] operand_addr = 8'h00;
	logic [5:0] acw_index = 6'h05;
	logic [WORD_W-1:0] function_word = '0, acw_data = '0, out_seen;
	logic [DATA_W-1:0] out_fill_data = '0, char_data = '0, in_data;
	logic [IDENT_W-1:0] identifier = {1'b0, 2'h1, 9'h003, 6'h05};
	logic out_fill_ready, in_data_valid, jump_function_pending, busy_timeout, monitor_interrupt;
	logic fast_suppressed, out_seen_valid, function_seen;
	logic [IDENT_W-1:0] last_identifier;
	logic [MSR_W-1:0] storage_module_select;
	logic [BIAS_W-1:0] block_base;
	logic [7:0] suppressed_target;
	logic irq_seen = 1'b0;
	int errors = 0, n_tests = 0, n;
	eic_link_if link();
	eic_processor i_eic_processor (.sys_clk, .nrst, .link, .chan_sel, .load_output_monitored,
		.load_input_monitored, .operand_addr, .load_function_channel_instr, .function_word,
		.jump_output_busy, .acw_write, .acw_index, .acw_data, .out_fill_data, .out_fill_valid,
		.out_fill_ready, .in_data, .in_data_valid, .in_data_ready, .jump_function_pending,
		.busy_timeout, .monitor_interrupt, .last_identifier, .storage_module_select,
		.block_base, .suppressed_target, .fast_suppressed);
	eic_controller i_eic_controller (.sys_clk, .nrst, .link, .char_ready, .char_data,
		.identifier, .want_output, .out_seen, .out_seen_valid, .function_seen);
	eic_props #(.GAP(FUNC_GAP_CYC)) i_eic_props (.sys_clk, .nrst, .out_word(link.out_word),
		.out_word_valid(link.out_word_valid), .function_strobe(link.function_strobe),
		.function_accept(link.function_accept), .output_data_request(link.output_data_request),
		.output_ack(link.output_ack), .input_data_request(link.input_data_request),
		.in_word(link.in_word), .input_ack(link.input_ack));
	// Free-running 200 MHz clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Interrupt is a one-cycle pulse, so latch it for later checks
	always @(posedge sys_clk) begin
		if (monitor_interrupt === 1'b1) irq_seen <= 1'b1;
	end
	task tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	task chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	task load_acw(input logic [WORD_W-1:0] w);
		acw_data <= w;
		acw_write <= 1'b1;
		tick(1);
		acw_write <= 1'b0;
	endtask : load_acw
	task send_char(input logic [DATA_W-1:0] d);
		char_data <= d;
		char_ready <= 1'b1;
		tick(1);
		char_ready <= 1'b0;
	endtask : send_char
	task wait_in;
		for (n = 0; n < 50 && in_data_valid !== 1'b1; n++) tick(1);
	endtask : wait_in
	// Busy wait with no request must end by the timeout count
	task t_timeout;
		jump_output_busy <= 1'b1;
		tick(1);
		jump_output_busy <= 1'b0;
		for (n = 1; n < 600 && busy_timeout !== 1'b1; n++) tick(1);
		chk(n >= BUSY_TIMEOUT_CYC && n < BUSY_TIMEOUT_CYC + 4, 1'b1);
		$display("test busy timeout done");
	endtask : t_timeout
	// Request before arming waits; two words drain a count of two
	task t_input;
		load_acw({18'h0_0002, 18'h0_0100});
		send_char(18'h0_0abc);
		tick(20);
		chk(in_data_valid, 1'b0);
		load_input_monitored <= 1'b1;
		tick(1);
		load_input_monitored <= 1'b0;
		wait_in();
		chk(in_data, 18'h0_0abc);
		chk(last_identifier, identifier);
		chk(storage_module_select, 2'h1);
		chk(block_base, 9'h003);
		chk(irq_seen, 1'b0);
		tick(2);
		send_char(18'h0_0def);
		wait_in();
		chk(in_data, 18'h0_0def);
		tick(3);
		chk(irq_seen, 1'b1);
		$display("test input done");
	endtask : t_input
	// Fill buffer till refused, send function, then one output word after the gap
	task t_output;
		load_acw({18'h0_0001, 18'h0_0200});
		out_fill_data <= 18'h0_0a01;
		out_fill_valid <= 1'b1;
		n = 0;
		repeat (4) begin
			tick(1);
			if (out_fill_ready === 1'b1) begin
				n++;
				out_fill_data <= out_fill_data + 18'h0_0001;
			end
		end
		out_fill_valid <= 1'b0;
		chk(n, 2);
		function_word <= 36'h0_0000_0011;
		load_function_channel_instr <= 1'b1;
		tick(1);
		load_function_channel_instr <= 1'b0;
		for (n = 0; n < 50 && function_seen !== 1'b1; n++) tick(1);
		tick(2);
		chk(jump_function_pending, 1'b0);
		operand_addr <= 8'h10;
		load_output_monitored <= 1'b1;
		tick(1);
		load_output_monitored <= 1'b0;
		tick(2);
		chk(fast_suppressed, 1'b1);
		chk(suppressed_target, 8'h31);
		want_output <= 1'b1;
		for (n = 0; n < 1000 && out_seen_valid !== 1'b1; n++) tick(1);
		chk(n >= FUNC_GAP_CYC - 8, 1'b1);
		chk(out_seen, {18'h0_0000, 18'h0_0a01});
		$display("test output done");
	endtask : t_output
	// Terminate function first, then the busy test must end on the standing request
	task t_drum;
		int hits;
		hits = 0;
		tick(4);
		function_word <= 36'h0_0000_0022;
		load_function_channel_instr <= 1'b1;
		tick(1);
		load_function_channel_instr <= 1'b0;
		tick(3);
		chk(jump_function_pending, 1'b0);
		jump_output_busy <= 1'b1;
		tick(1);
		jump_output_busy <= 1'b0;
		repeat (420) begin
			tick(1);
			if (busy_timeout !== 1'b0) hits++;
		end
		chk(hits, 0);
		want_output <= 1'b0;
		$display("test drum busy done");
	endtask : t_drum
	// Main sequence
	initial begin
		tick(8);
		nrst <= 1'b1;
		tick(2);
		chk(jump_function_pending, 1'b0);
		t_timeout();
		t_input();
		t_output();
		t_drum();
		conclude();
	end
	// Watchdog well past the expected run length
	initial begin
		#50000;
		errors++;
		conclude();
	end
endmodule : tb
